// file: verilog/ocf_config_flags.sv
/*
 Configuration flag registers: FIFO purge on port open/close, per-field
 programmed flags with write-once protection, and the status pin setup.
 Assumes a simple synchronous byte register port from the USB control path
 and single-cycle open/close event pulses.
*/
`timescale 1ns/1ps
module ocf_config_flags (
	input wire logic clk,
	input wire logic reset,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [ocf_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_wr_refused,
	input wire logic port_open,
	input wire logic port_close,
	output logic tx_fifo_purge,
	output logic rx_fifo_purge,
	output logic fifo_accept_hold,
	input wire logic [ocf_pkg::NUM_FIELDS-1:0] field_wr,
	output logic [ocf_pkg::NUM_FIELDS-1:0] field_wr_allow,
	output logic [ocf_pkg::NUM_FIELDS-1:0] field_use_otp,
	input wire logic usb_suspend,
	input wire logic usb_low_power,
	input wire logic usb_bus_reset,
	output logic bus_status_output_one,
	output logic bus_status_output_one_oe
);

	// Register storage
	logic [7:0] purge_q;
	logic [7:0] purge_d;
	logic [7:0] flags_a_q;
	logic [7:0] flags_a_d;
	logic [7:0] flags_b_q;
	logic [7:0] flags_b_d;
	logic [7:0] stat1_q;
	logic [7:0] stat1_d;
	logic [7:0] rdata_d;
	logic [7:0] rdata_q;
	logic refused_d;
	logic refused_q;
	ocf_pkg::ocf_purge_t purge_ev_d;
	ocf_pkg::ocf_purge_t purge_ev_q;
	logic [ocf_pkg::NUM_FIELDS-1:0] flags_all;

	// Flag bit for a register offset covered by a field flag
	function automatic logic guard_flag(input logic [ocf_pkg::ADDR_W-1:0] a,
		input logic [7:0] fb);
		guard_flag = 1'b0;
		if (a == ocf_pkg::OFF_PURGE) begin
			guard_flag = fb[ocf_pkg::FB_PURGE];
		end
	endfunction : guard_flag

	assign flags_all = {flags_b_q, flags_a_q};

	// Register writes, read mux and purge events
	always_comb begin
		purge_d = purge_q;
		flags_a_d = flags_a_q;
		flags_b_d = flags_b_q;
		stat1_d = stat1_q;
		refused_d = 1'b0;
		rdata_d = rdata_q;
		if (reg_wr) begin
			if (guard_flag(reg_addr, flags_b_q)) begin
				refused_d = 1'b1;
			end else begin
				unique case (reg_addr)
					ocf_pkg::OFF_PURGE: purge_d = reg_wdata & ocf_pkg::PURGE_MASK;
					// Flags only ever set; a set flag is cleared only by reset
					ocf_pkg::OFF_FLAGS_A:
						flags_a_d = flags_a_q | (reg_wdata & ocf_pkg::FLAGS_A_MASK);
					ocf_pkg::OFF_FLAGS_B: flags_b_d = flags_b_q | reg_wdata;
					ocf_pkg::OFF_STAT1: begin
						if (flags_a_q[ocf_pkg::FA_UART_PINS]) begin
							refused_d = 1'b1;
						end else begin
							stat1_d = reg_wdata & ocf_pkg::STAT1_MASK;
						end
					end
					default: refused_d = 1'b0;
				endcase
			end
		end
		if (reg_rd) begin
			unique case (reg_addr)
				ocf_pkg::OFF_PURGE: rdata_d = purge_q;
				ocf_pkg::OFF_FLAGS_A: rdata_d = flags_a_q;
				ocf_pkg::OFF_FLAGS_B: rdata_d = flags_b_q;
				ocf_pkg::OFF_STAT1: rdata_d = stat1_q;
				default: rdata_d = 8'h00;
			endcase
		end
		// Purge settings honoured only once their field is flagged
		purge_ev_d.rx_purge = flags_b_q[ocf_pkg::FB_PURGE] & (
			(port_close & purge_q[ocf_pkg::PB_RX_CLOSE]) |
			(port_open & purge_q[ocf_pkg::PB_RX_OPEN]));
		purge_ev_d.tx_purge = flags_b_q[ocf_pkg::FB_PURGE] & (
			(port_close & purge_q[ocf_pkg::PB_TX_CLOSE]) |
			(port_open & purge_q[ocf_pkg::PB_TX_OPEN]));
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			purge_q <= ocf_pkg::RST_PURGE;
			flags_a_q <= ocf_pkg::RST_FLAGS_A;
			flags_b_q <= ocf_pkg::RST_FLAGS_B;
			stat1_q <= ocf_pkg::RST_STAT1;
			rdata_q <= 8'h00;
			refused_q <= 1'b0;
			purge_ev_q <= '0;
		end else begin
			purge_q <= purge_d;
			flags_a_q <= flags_a_d;
			flags_b_q <= flags_b_d;
			stat1_q <= stat1_d;
			rdata_q <= rdata_d;
			refused_q <= refused_d;
			purge_ev_q <= purge_ev_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign reg_wr_refused = refused_q;
	assign tx_fifo_purge = purge_ev_q.tx_purge;
	assign rx_fifo_purge = purge_ev_q.rx_purge;
	// Hold FIFO intake from the event cycle until the purge pulse is done
	assign fifo_accept_hold = purge_ev_q.tx_purge | purge_ev_q.rx_purge
		| purge_ev_d.tx_purge | purge_ev_d.rx_purge;

	// Per-field OTP use and write-once gating
	genvar gi;
	generate
		for (gi = 0; gi < ocf_pkg::NUM_FIELDS; gi++) begin : g_field
			assign field_use_otp[gi] = flags_all[gi];
			assign field_wr_allow[gi] = field_wr[gi] & ~flags_all[gi];
		end
	endgenerate

	ocf_pkg::ocf_pin_cfg_t pin_cfg;
	ocf_pkg::ocf_usb_state_t usb_state;

	assign pin_cfg.sel = stat1_q[ocf_pkg::ST_SEL_LSB +: 3];
	assign pin_cfg.drv = stat1_q[ocf_pkg::ST_DRV_LSB +: 2];
	assign usb_state.suspend = usb_suspend;
	assign usb_state.low_power = usb_low_power;
	assign usb_state.bus_reset = usb_bus_reset;

	ocf_stat_pin u_stat_pin (
		.clk(clk),
		.reset(reset),
		.cfg(pin_cfg),
		.usb(usb_state),
		.pin_o(bus_status_output_one),
		.pin_oe(bus_status_output_one_oe)
	);

endmodule : ocf_config_flags

// file: verilog/ocf_pkg.sv
/*
 Package for the configuration-flag block: register offsets, field positions,
 reset values and the carrier structs shared by the top and its pin driver.
 Assumes an 8-bit register port with byte addresses as printed.
*/
package ocf_pkg;

	localparam int ADDR_W = 9;
	localparam logic [8:0] OFF_PURGE = 9'h01a;
	localparam logic [8:0] OFF_FLAGS_A = 9'h01d;
	localparam logic [8:0] OFF_FLAGS_B = 9'h01e;
	localparam logic [8:0] OFF_STAT1 = 9'h01f;

	localparam logic [7:0] RST_PURGE = 8'h00;
	localparam logic [7:0] RST_FLAGS_A = 8'h00;
	localparam logic [7:0] RST_FLAGS_B = 8'h00;
	localparam logic [7:0] RST_STAT1 = 8'h00;

	// Purge register bits
	localparam int PB_TX_OPEN = 0;
	localparam int PB_TX_CLOSE = 1;
	localparam int PB_RX_OPEN = 2;
	localparam int PB_RX_CLOSE = 3;
	localparam logic [7:0] PURGE_MASK = 8'h0f;

	// Flag byte A bits
	localparam int FA_PROD_ONE = 0;
	localparam int FA_PROD_TWO = 1;
	localparam int FA_SERIAL = 2;
	localparam int FA_UART_PINS = 3;
	localparam int FA_LANG = 7;
	localparam logic [7:0] FLAGS_A_MASK = 8'h8f;

	// Flag byte B bits
	localparam int FB_VID = 0;
	localparam int FB_PID = 1;
	localparam int FB_MAX_POWER = 2;
	localparam int FB_ATTR = 3;
	localparam int FB_RELEASE = 4;
	localparam int FB_PURGE = 5;
	localparam int FB_MAKER_ONE = 6;
	localparam int FB_MAKER_TWO = 7;

	// Status pin register fields
	localparam int ST_SEL_LSB = 2;
	localparam int ST_DRV_LSB = 0;
	localparam logic [7:0] STAT1_MASK = 8'h1f;
	localparam logic [1:0] DRV_OPEN_DRAIN = 2'h1;
	localparam logic [1:0] DRV_PUSH_PULL = 2'h2;

	// Field numbering for the sixteen programmed flags: {byte B, byte A}
	localparam int NUM_FIELDS = 16;

	typedef struct packed {
		logic suspend;
		logic low_power;
		logic bus_reset;
	} ocf_usb_state_t;

	typedef struct packed {
		logic [2:0] sel;
		logic [1:0] drv;
	} ocf_pin_cfg_t;

	typedef struct packed {
		logic tx_purge;
		logic rx_purge;
	} ocf_purge_t;

endpackage : ocf_pkg

// file: verilog/ocf_stat_pin.sv
/*
 USB-state driver of the first bus status output pin.
 Assumes the USB state levels are synchronous to clk.
*/
`timescale 1ns/1ps
module ocf_stat_pin (
	input wire logic clk,
	input wire logic reset,
	input wire ocf_pkg::ocf_pin_cfg_t cfg,
	input wire ocf_pkg::ocf_usb_state_t usb,
	output logic pin_o,
	output logic pin_oe
);

	logic level_d;
	logic level_q;
	logic oe_d;
	logic oe_q;

	always_comb begin
		unique case (cfg.sel)
			3'h0, 3'h4: level_d = usb.suspend | usb.bus_reset;
			3'h1: level_d = usb.suspend;
			3'h2: level_d = usb.low_power;
			3'h3: level_d = usb.bus_reset;
			3'h5: level_d = ~usb.suspend;
			3'h6: level_d = ~usb.low_power;
			3'h7: level_d = ~usb.bus_reset;
		endcase
		// Open drain only drives low; invalid codes leave the pin undriven
		unique case (cfg.drv)
			ocf_pkg::DRV_OPEN_DRAIN: oe_d = ~level_d;
			ocf_pkg::DRV_PUSH_PULL: oe_d = 1'b1;
			default: oe_d = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			level_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			level_q <= level_d;
			oe_q <= oe_d;
		end
	end

	assign pin_o = level_q;
	assign pin_oe = oe_q;

endmodule : ocf_stat_pin

// file: verification/ocf_assertions.sv
/* Checker of the flag block ports.
 Assumes binding to ocf_config_flags. */
`timescale 1ns/1ps
module ocf_chk (
	input wire logic clk,
	input wire logic reset,
	input wire logic reg_wr,
	input wire logic [ocf_pkg::ADDR_W-1:0] reg_addr,
	input wire logic reg_wr_refused,
	input wire logic port_open,
	input wire logic port_close,
	input wire logic tx_fifo_purge,
	input wire logic rx_fifo_purge,
	input wire logic fifo_accept_hold,
	input wire logic [15:0] field_wr,
	input wire logic [15:0] field_wr_allow,
	input wire logic [15:0] field_use_otp
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic ev;
	logic pf;
	assign ev = port_open | port_close;
	assign pf = field_use_otp[13];
	event_hold_a: assert property (
		tx_fifo_purge | rx_fifo_purge |-> $past(fifo_accept_hold)) else $error("no hold");
	purge_hold_a: assert property (
		tx_fifo_purge | rx_fifo_purge |-> fifo_accept_hold) else $error("no hold");
	tx_cause_a: assert property (
		tx_fifo_purge |-> $past(ev) && $past(pf)) else $error("tx purge");
	rx_cause_a: assert property (
		rx_fifo_purge |-> $past(ev) && $past(pf)) else $error("rx purge");
	allow_gate_a: assert property (
		field_wr_allow == (field_wr & ~field_use_otp)) else $error("allow");
	flag_keep_a: assert property (
		(field_use_otp & $past(field_use_otp)) == $past(field_use_otp)) else $error("lost");
	purge_lock_a: assert property (
		reg_wr && reg_addr == ocf_pkg::OFF_PURGE && pf |=> reg_wr_refused) else $error("purge");
	stat_lock_a: assert property (
		reg_wr && reg_addr == ocf_pkg::OFF_STAT1 && field_use_otp[3] |=> reg_wr_refused)
		else $error("stat");
endmodule : ocf_chk
bind ocf_config_flags ocf_chk u_chk (.clk, .reset, .reg_wr, .reg_addr, .reg_wr_refused,
	.port_open, .port_close, .tx_fifo_purge, .rx_fifo_purge, .fifo_accept_hold,
	.field_wr, .field_wr_allow, .field_use_otp);

// file: verification/ocf_host.sv
/* Host model: byte register accesses.
 Assumes tasks are entered at a rising edge. */
`timescale 1ns/1ps
module ocf_host (
	input wire logic clk,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_wr_refused,
	output logic reg_wr,
	output logic reg_rd,
	output logic [8:0] reg_addr,
	output logic [7:0] reg_wdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 9'h000;
		reg_wdata = 8'h00;
	end
	task automatic wr(input logic [8:0] a, input logic [7:0] v, output logic r);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~v;
		#1 r = reg_wr_refused;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [8:0] a, output logic [7:0] v);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1 v = reg_rdata;
		@(posedge clk);
	endtask : rd
endmodule : ocf_host

// file: verification/tb_top.sv
/* Testbench: registers, purge, flags, status pin.
 Assumes the host model drives the register port. */
`timescale 1ns/1ps
module tb_top;
	logic clk, reset, port_open, port_close, usb_suspend, usb_low_power, usb_bus_reset;
	logic reg_wr, reg_rd, reg_wr_refused, tx_fifo_purge, rx_fifo_purge, fifo_accept_hold;
	logic bus_status_output_one, bus_status_output_one_oe, r, p;
	logic [8:0] reg_addr;
	logic [7:0] reg_rdata, reg_wdata, d;
	logic [15:0] field_wr, field_wr_allow, field_use_otp;
	logic [8:0] offs [5] = '{9'h01a, 9'h01d, 9'h01e, 9'h01f, 9'h01b};
	int error_cnt, comparisons;
	ocf_config_flags uut (.clk, .reset, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
		.reg_wr_refused, .port_open, .port_close, .tx_fifo_purge, .rx_fifo_purge,
		.fifo_accept_hold, .field_wr, .field_wr_allow, .field_use_otp, .usb_suspend,
		.usb_low_power, .usb_bus_reset, .bus_status_output_one, .bus_status_output_one_oe);
	ocf_host host (.clk, .reg_rdata, .reg_wr_refused, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic w(input logic [8:0] a, input logic [7:0] v, input logic e);
		host.wr(a, v, r);
		chk(r, e);
	endtask : w
	task automatic rc(input logic [8:0] a, input logic [7:0] e);
		host.rd(a, d);
		chk(d, e);
	endtask : rc
	task automatic ev(input logic o, input logic [1:0] e);
		port_open <= o;
		port_close <= !o;
		#1 chk(fifo_accept_hold, |e);
		@(posedge clk);
		port_open <= 1'b0;
		port_close <= 1'b0;
		#1 chk({tx_fifo_purge, rx_fifo_purge}, e);
		@(posedge clk);
	endtask : ev
	function automatic logic lvl(input logic [2:0] c, input logic [2:0] k);
		case (c)
			3'h0, 3'h4: return k[2] | k[0];
			3'h1: return k[2];
			3'h2: return k[1];
			3'h3: return k[0];
			3'h5: return !k[2];
			3'h6: return !k[1];
			default: return !k[0];
		endcase
	endfunction : lvl
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (6000) @(posedge clk);
		error_cnt++;
		give_verdict();
	end
	initial begin
		{reset, port_open, port_close, usb_suspend, usb_low_power, usb_bus_reset} = 6'h20;
		field_wr = 16'h0000;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		foreach (offs[i]) rc(offs[i], 8'h00);
		$display("test reset values done");
		for (int m = 1; m < 3; m++) begin
			for (int c = 0; c < 8; c++) begin
				w(9'h01f, {3'h0, c[2:0], m[1:0]}, 1'b0);
				rc(9'h01f, {3'h0, c[2:0], m[1:0]});
				for (int k = 0; k < 8; k++) begin
					{usb_suspend, usb_low_power, usb_bus_reset} <= k[2:0];
					@(posedge clk);
					p = lvl(c[2:0], k[2:0]);
					#1 chk({bus_status_output_one, bus_status_output_one_oe}, {p, m == 2 || !p});
					@(posedge clk);
				end
			end
		end
		$display("test status pin done");
		w(9'h01a, 8'h09, 1'b0);
		rc(9'h01a, 8'h09);
		ev(1'b1, 2'h0);
		w(9'h01e, 8'h20, 1'b0);
		ev(1'b1, 2'h2);
		ev(1'b0, 2'h1);
		ev(1'b0, 2'h1);
		w(9'h01a, 8'h06, 1'b1);
		rc(9'h01a, 8'h09);
		$display("test purge done");
		w(9'h01e, 8'h41, 1'b0);
		rc(9'h01e, 8'h61);
		w(9'h01d, 8'h8c, 1'b0);
		rc(9'h01d, 8'h8c);
		chk(field_use_otp, 16'h618c);
		field_wr <= 16'hffff;
		@(posedge clk);
		#1 chk(field_wr_allow, 16'h9e73);
		@(posedge clk);
		w(9'h01f, 8'h06, 1'b1);
		$display("test flags done");
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		rc(9'h01e, 8'h00);
		$display("test second reset done");
		give_verdict();
	end
endmodule : tb_top
